/* byte_word_assembler.sv */
// Gathers big-endian bytes into 32-bit words.
// Assumes bytes arrive on the core clock, one per valid cycle.
`timescale 1ns/10ps
`default_nettype none
module byte_word_assembler
  import cmd_packet_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clear,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  output logic      [31:0] word_out
);
  logic [31:0] word_reg;
  logic [31:0] word_next;

  assign word_next = clear      ? 32'h0000_0000 :
                     byte_valid ? {word_reg[23:0], byte_data} : word_reg;
  assign word_out  = word_next;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      word_reg <= 32'h0000_0000;
    end else begin
      word_reg <= word_next;
    end
  end
endmodule
`default_nettype wire

/* cmd_packet_params.svh */
// Constants for the command packet checker.
// Assumes inclusion by the checker and its bench; holds definitions only.
`ifndef CMD_PACKET_PARAMS_SVH
`define CMD_PACKET_PARAMS_SVH

`define PKT_BYTES          6'd58
`define PKT_VERSION        3'h0
`define PKT_TYPE_CMD       1'b1
`define PKT_SEC_HDR        1'b1
`define PKT_SEG_UNSEG      2'h3
`define PKT_DATA_LEN       16'h0033
`define HDR_WORD0_BYTE     6'd3
`define HDR_WORD1_BYTE     6'd7
`define TS_SEC_BYTE        6'd9
`define TS_USEC_BYTE       6'd13
`define CODE_WORD_BYTE     6'd15
`define ARG_FIRST_BYTE     6'd18
`define ARG_COUNT          10

// APB register offsets and control register reset value
`define REG_STATUS         12'h000
`define REG_CTRL           12'h004
`define REG_CODE           12'h008
`define REG_SEQ            12'h00C
`define REG_TS_SEC         12'h010
`define REG_TS_USEC        12'h014
`define REG_VALID_CNT      12'h018
`define REG_INVALID_CNT    12'h01C
`define REG_ARG_BASE       12'h020
`define REG_HDR            12'h048
`define CTRL_RESET_VAL     32'h0000_0001

`endif

/* cmd_packet_pkg.sv */
// Types shared by the command packet checker.
// Assumes cmd_packet_params.svh is compiled alongside.
package cmd_packet_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       last;
  } rx_byte_t;

  typedef struct packed {
    logic [2:0]  version;
    logic        pkt_type;
    logic        sec_hdr;
    logic [10:0] source_app_identifier;
    logic [1:0]  seg_flags;
    logic [13:0] seq_count;
    logic [15:0] data_len;
  } primary_hdr_t;

  typedef struct packed {
    logic        version_bad;
    logic        type_bad;
    logic        sec_hdr_bad;
    logic        seg_bad;
    logic        len_bad;
    logic        size_bad;
  } check_flags_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_DROP = 2'b10
  } rx_state_t;

endpackage

/* command_packet_checker.sv */
// Command packet receiver and checker with an APB register file.
// Assumes frame removal and CRC check are done upstream; bytes arrive
// on the core clock with a last mark on the final byte of each packet.
//
// How it works
// - packet must be exactly 58 bytes
// - fields packed back to back from byte 0, most significant byte first
// - version 000 and type one required
// - secondary header flag must be one
// - source identifier sent zero, kept visible
// - segmentation flags both set; 14-bit count
// - data length field must equal 51
// - timestamp seconds and microseconds extracted
// - reserved half word ignored
// - ten 32-bit arguments presented separately
// - upstream frame CRC passed before acceptance
// - status shows whether a command arrived
`timescale 1ns/10ps
`default_nettype none
`include "cmd_packet_params.svh"
module command_packet_checker
  import cmd_packet_pkg::*;
#(
  parameter int ARGS = `ARG_COUNT
)(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire rx_byte_t    rx_in,
  input  wire logic        frame_crc_ok,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cmd_valid,
  output logic             cmd_invalid,
  output logic      [15:0] command_code,
  output logic      [31:0] cmd_args [ARGS]
);

  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // ********************************************************
  // Byte reception
  // ********************************************************
  rx_state_t    state_reg, state_next;
  logic [5:0]   count_reg;
  logic [31:0]  word;
  primary_hdr_t hdr_reg;
  logic [31:0]  ts_sec_reg, ts_usec_reg;
  logic [15:0]  code_reg;
  logic [31:0]  args_reg [ARGS];
  logic         valid_reg, invalid_reg, seen_reg, enable_reg;
  logic [31:0]  valid_cnt_reg, invalid_cnt_reg;
  check_flags_t flags;
  logic         byte_in, end_pkt, accept;
  logic [5:0]   count_next;

  assign byte_in   = rx_in.valid && enable_reg;
  assign end_pkt   = byte_in && rx_in.last;
  assign count_next = (count_reg == 6'h3F) ? count_reg : count_reg + 6'd1;

  byte_word_assembler u_asm (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .clear      (state_reg == ST_IDLE && !byte_in),
    .byte_valid (byte_in),
    .byte_data  (rx_in.data),
    .word_out   (word)
  );

  // ********************************************************
  // Header checks
  // ********************************************************
  // version and type verified
  assign flags.version_bad = hdr_reg.version  != `PKT_VERSION;
  assign flags.type_bad    = hdr_reg.pkt_type != `PKT_TYPE_CMD;
  assign flags.sec_hdr_bad = hdr_reg.sec_hdr  != `PKT_SEC_HDR;
  assign flags.seg_bad     = hdr_reg.seg_flags != `PKT_SEG_UNSEG;
  assign flags.len_bad     = hdr_reg.data_len != `PKT_DATA_LEN;
  assign flags.size_bad    = count_reg != (`PKT_BYTES - 6'd1);
  assign accept = end_pkt && (state_reg == ST_RECV || count_reg == 6'd0)
                  && !(|flags) && frame_crc_ok;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (byte_in && !rx_in.last) state_next = ST_RECV;
      ST_RECV: if (end_pkt) state_next = ST_IDLE;
               else if (byte_in && count_reg == `PKT_BYTES - 6'd1)
                 state_next = ST_DROP;
      ST_DROP: if (end_pkt) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      count_reg <= 6'd0;
    end else begin
      state_reg <= state_next;
      count_reg <= end_pkt ? 6'd0 : (byte_in ? count_next : count_reg);
    end
  end

  // ********************************************************
  // Field capture
  // ********************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hdr_reg     <= '0;
      ts_sec_reg  <= 32'h0000_0000;
      ts_usec_reg <= 32'h0000_0000;
      code_reg    <= 16'h0000;
    end else if (byte_in) begin
      if (count_reg == `HDR_WORD0_BYTE) hdr_reg[47:16] <= word;
      if (count_reg == `HDR_WORD1_BYTE) hdr_reg[15:0]  <= word[31:16];
      if (count_reg == `TS_SEC_BYTE)    ts_sec_reg     <= word;
      if (count_reg == `TS_USEC_BYTE)   ts_usec_reg    <= word;
      if (count_reg == `CODE_WORD_BYTE) code_reg       <= word[15:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ARGS; gi++) begin : g_arg
      localparam logic [5:0] ENDB = 6'(`ARG_FIRST_BYTE + 4 * gi + 3);
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          args_reg[gi] <= 32'h0000_0000;
        end else if (byte_in && count_reg == ENDB) begin
          args_reg[gi] <= word;
        end
      end
      assign cmd_args[gi] = args_reg[gi];
      chk_arg_word: assert property (
        byte_in && count_reg == ENDB |=> args_reg[gi] == $past(word))
        else $error("argument word not captured");
    end
  endgenerate

  // ********************************************************
  // Outcome
  // ********************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      valid_reg       <= 1'b0;
      invalid_reg     <= 1'b0;
      command_code    <= 16'h0000;
      valid_cnt_reg   <= 32'h0000_0000;
      invalid_cnt_reg <= 32'h0000_0000;
    end else begin
      valid_reg   <= accept;
      invalid_reg <= end_pkt && !accept;
      if (accept) begin
        command_code  <= code_reg;
        valid_cnt_reg <= valid_cnt_reg + 32'd1;
      end
      if (end_pkt && !accept) invalid_cnt_reg <= invalid_cnt_reg + 32'd1;
    end
  end
  assign cmd_valid   = valid_reg;
  assign cmd_invalid = invalid_reg;

  // ********************************************************
  // APB registers
  // ********************************************************
  logic        wr_en, rd_sel, status_rd, addr_ok;
  logic [3:0]  arg_idx;
  logic [31:0] rd_mux;

  assign wr_en     = psel && penable && pwrite;
  assign status_rd = psel && penable && !pwrite && paddr == `REG_STATUS;
  assign arg_idx   = 4'((paddr - `REG_ARG_BASE) >> 2);
  assign rd_sel    = paddr >= `REG_ARG_BASE && paddr < `REG_HDR;
  assign addr_ok   = paddr[1:0] == 2'b00 && paddr <= `REG_HDR;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_ok;

  always_comb begin
    case (paddr)
      `REG_STATUS:      rd_mux = {30'h0, invalid_reg, seen_reg};
      `REG_CTRL:        rd_mux = {31'h0, enable_reg};
      `REG_CODE:        rd_mux = {16'h0, command_code};
      `REG_SEQ:         rd_mux = {21'h0, hdr_reg.source_app_identifier};
      `REG_TS_SEC:      rd_mux = ts_sec_reg;
      `REG_TS_USEC:     rd_mux = ts_usec_reg;
      `REG_VALID_CNT:   rd_mux = valid_cnt_reg;
      `REG_INVALID_CNT: rd_mux = invalid_cnt_reg;
      `REG_HDR:         rd_mux = {2'h0, hdr_reg.seq_count, hdr_reg.data_len};
      default:          rd_mux = rd_sel ? args_reg[arg_idx] : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enable_reg <= 1'b1;
      seen_reg   <= 1'b0;
    end else begin
      if (wr_en && paddr == `REG_CTRL) enable_reg <= pwdata[0];
      if (valid_reg) seen_reg <= 1'b1;
      else if (status_rd) seen_reg <= 1'b0;
    end
  end
  assign prdata = rd_mux;

  // ********************************************************
  // Checks
  // ********************************************************
  sequence s_good_end;
    accept;
  endsequence

  sequence s_bad_end;
    end_pkt && !accept;
  endsequence

  sequence s_hdr_word;
    byte_in && count_reg == `HDR_WORD0_BYTE;
  endsequence

  chk_valid_pulse: assert property (
    s_good_end |=> cmd_valid && !cmd_invalid)
    else $error("valid pulse missing");
  chk_bad_pulse: assert property (
    s_bad_end |=> cmd_invalid && !cmd_valid)
    else $error("invalid pulse missing");
  chk_one_outcome: assert property (
    !(cmd_valid && cmd_invalid))
    else $error("both outcomes shown at once");
  chk_bad_size: assert property (
    end_pkt && count_reg != 6'd57 |=> !cmd_valid && cmd_invalid)
    else $error("wrong size accepted");
  chk_size_exact: assert property (
    accept |-> count_reg == 6'd57)
    else $error("accepted packet not 58 bytes");
  chk_drop_bad: assert property (
    state_reg == ST_DROP && end_pkt |=> cmd_invalid)
    else $error("overlong packet not flagged");
  chk_version_bad: assert property (
    end_pkt && hdr_reg.version != 3'h0 |=> cmd_invalid)
    else $error("bad version accepted");
  chk_type_bad: assert property (
    end_pkt && hdr_reg.pkt_type != 1'b1 |=> !cmd_valid)
    else $error("telemetry type accepted");
  chk_sec_flag: assert property (
    end_pkt && !hdr_reg.sec_hdr |=> !cmd_valid)
    else $error("missing secondary header accepted");
  chk_seg_flags: assert property (
    end_pkt && hdr_reg.seg_flags != 2'h3 |=> !cmd_valid)
    else $error("segmented packet accepted");
  chk_len_field: assert property (
    end_pkt && hdr_reg.data_len != 16'd51 |=> !cmd_valid)
    else $error("bad length accepted");
  chk_crc_gate: assert property (
    end_pkt && !frame_crc_ok |=> !cmd_valid)
    else $error("crc failure accepted");
  chk_hdr_capture: assert property (
    s_hdr_word |=> hdr_reg[47:16] == $past(word))
    else $error("header word not captured");
  chk_ts_capture: assert property (
    byte_in && count_reg == `TS_SEC_BYTE |=> ts_sec_reg == $past(word))
    else $error("seconds word not captured");
  chk_code_out: assert property (
    accept |=> command_code == $past(code_reg))
    else $error("command code not presented");
  chk_code_hold: assert property (
    !accept |=> $stable(command_code))
    else $error("command code changed without packet");
  chk_valid_count: assert property (
    cmd_valid |-> valid_cnt_reg == $past(valid_cnt_reg) + 32'd1)
    else $error("valid count not stepped");
  chk_invalid_count: assert property (
    cmd_invalid |-> invalid_cnt_reg == $past(invalid_cnt_reg) + 32'd1)
    else $error("invalid count not stepped");
  chk_seen_set: assert property (
    cmd_valid |=> seen_reg)
    else $error("arrival not shown in status");
  chk_seen_clear: assert property (
    status_rd && !valid_reg |=> !seen_reg)
    else $error("status read did not clear arrival");

endmodule
`default_nettype wire

/* command_packet_checker_tb.sv */
// Self-checking bench for the command packet checker.
// Assumes the design files and host_sender.sv are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "cmd_packet_params.svh"
module command_packet_checker_tb;
  import cmd_packet_pkg::*;
  logic        core_clk, rst_n, psel, penable, pwrite, err;
  logic        pready, pslverr, cmd_valid, cmd_invalid, frame_crc_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, ts_s, ts_u;
  logic [31:0] cmd_args [`ARG_COUNT];
  logic [31:0] exp_args [`ARG_COUNT];
  logic [15:0] command_code, exp_code;
  logic [13:0] seq;
  logic [7:0]  pkt [$];
  rx_byte_t    rx_in;
  int          n_errors, comparisons, n_ok, n_bad;

  command_packet_checker #(.ARGS(`ARG_COUNT)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .rx_in(rx_in),
    .frame_crc_ok(frame_crc_ok), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid),
    .cmd_invalid(cmd_invalid), .command_code(command_code),
    .cmd_args(cmd_args));
  host_sender u_host (.core_clk(core_clk), .rx_in(rx_in),
    .frame_crc_ok(frame_crc_ok));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd, e);
    cmp(32'(err), 32'(a > `REG_HDR));
  endtask

  task automatic build(input int f, input bit en);
    logic [463:0] v;
    logic [15:0]  c;
    c = 16'(rnd());
    // count steps by one and wraps
    seq++;
    v[463:320] = {3'(f == 1), f != 2, f != 3, 11'h000,
                  f == 4 ? 2'h2 : 2'h3, seq,
                  f == 5 ? 16'h0032 : 16'h0033, rnd(), rnd(), c, 16'h0};
    foreach (exp_args[i]) begin
      exp_args[i] = rnd();
      v[319 - 32 * i -: 32] = exp_args[i];
    end
    if (f == 0 && en) begin
      exp_code = c;
      ts_s = v[415:384];
      ts_u = v[383:352];
    end
    pkt.delete();
    for (int i = 57; i >= 0; i--) pkt.push_back(v[8 * i +: 8]);
    if (f == 6) void'(pkt.pop_back());
    if (f == 7) pkt.push_back(8'hA5);
  endtask

  task automatic run(input int f, input bit slow, input bit en);
    build(f, en);
    u_host.send(pkt, f != 8, slow);
    #1;
    cmp(32'(cmd_valid), 32'(en && f == 0));
    cmp(32'(cmd_invalid), 32'(en && f != 0));
    cmp(32'(command_code), 32'(exp_code));
    if (en && f == 0) begin
      n_ok++;
      foreach (exp_args[i]) cmp(cmd_args[i], exp_args[i]);
    end
    if (en && f != 0) n_bad++;
  endtask

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_errors = 0;
    comparisons = 0;
    n_ok = 0;
    n_bad = 0;
    seed = 32'h0000_00F4;
    seq = 14'h3FFD;
    exp_code = 16'h0000;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(`REG_CTRL, 32'h0000_0001);
    run(0, 1'b0, 1'b1);
    run(0, 1'b1, 1'b1);
    for (int f = 1; f < 9; f++) run(f, f[0], 1'b1);
    for (int k = 0; k < 12; k++) run(rnd() % 9, rnd() % 2, 1'b1);
    run(0, 1'b0, 1'b1);
    rd_chk(`REG_CODE, 32'(exp_code));
    rd_chk(`REG_SEQ, 32'h0);
    rd_chk(`REG_TS_SEC, ts_s);
    rd_chk(`REG_TS_USEC, ts_u);
    for (int i = 0; i < 10; i++)
      rd_chk(`REG_ARG_BASE + 12'(4 * i), exp_args[i]);
    apb(1'b0, `REG_HDR, 32'h0);
    cmp(rd & 32'h3FFF_FFFF, {2'h0, seq, 16'h0033});
    apb(1'b0, `REG_STATUS, 32'h0);
    cmp(rd & 32'h3, 32'h1);
    apb(1'b0, `REG_STATUS, 32'h0);
    cmp(rd & 32'h1, 32'h0);
    rd_chk(`REG_VALID_CNT, n_ok);
    rd_chk(`REG_INVALID_CNT, n_bad);
    rd_chk(12'h04C, 32'h0);
    apb(1'b1, `REG_CTRL, 32'h0);
    run(0, 1'b0, 1'b0);
    apb(1'b1, `REG_CTRL, 32'h1);
    run(0, 1'b1, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* host_sender.sv */
// Host side model: sends command packets as a byte stream.
// Assumes the bench owns the clock and has reset the receiver first.
`timescale 1ns/10ps
`default_nettype none
module host_sender
  import cmd_packet_pkg::*;
(
  input  wire logic core_clk,
  output var rx_byte_t rx_in,
  output var logic  frame_crc_ok
);
  logic [7:0] prev;
  initial begin
    rx_in = '0;
    frame_crc_ok = 1'b0;
    prev = 8'h00;
  end
  task automatic send(input logic [7:0] q[$], input logic crc,
                      input bit slow);
    foreach (q[i]) begin
      if (slow && i > 0) begin
        @(posedge core_clk);
        rx_in <= '{data: ~prev, valid: 1'b0, last: 1'b0};
      end
      @(posedge core_clk);
      rx_in <= '{data: q[i], valid: 1'b1, last: i == q.size() - 1};
      frame_crc_ok <= crc;
      prev = q[i];
    end
    // Idle data line shows no stale byte
    @(posedge core_clk);
    rx_in <= '{data: ~prev, valid: 1'b0, last: 1'b0};
    frame_crc_ok <= ~crc;
  endtask
endmodule
`default_nettype wire
